// file: hw/aphi_top.v
// Algorithmic phase initialization sequencer with APB registers and commutation
`timescale 1ns/1ns
`default_nettype none
`include "aphi_defs.vh"
module aphi_top #(
	parameter AW = 8,
	parameter SW = 32
) (
	// Clock, reset, enable
	input wire pclk,
	input wire presetn,
	input wire ce,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [AW-1:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata_q,
	output reg pready_q,
	output reg pslverr_q,
	// Encoder pins
	input wire enc_a,
	input wire enc_b,
	input wire enc_idx,
	// Servo filter command for closed loop
	input wire [15:0] servo_cmd,
	// Amplifier outputs
	output reg [15:0] phase_a_q,
	output reg [15:0] phase_b_q,
	output reg [15:0] phase_c_q,
	output reg [2:0] phase_sign_q,
	output reg [2:0] fmt_sel_q
);
	// Sequencer states, one-hot
	localparam [2:0] S_IDLE = 3'b001;
	localparam [2:0] S_STEP1 = 3'b010;
	localparam [2:0] S_STEP2 = 3'b100;

	reg [2:0] state_q;
	reg [1:0] outfmt_q;
	reg [1:0] phases_q;
	reg [15:0] cpc_q;
	reg method_q;
	reg loop_on_q;
	reg [SW-1:0] settle_q;
	reg [15:0] drive_q;
	reg [15:0] applied_q;
	reg [2:0] pol_q;
	reg idxcorr_q;
	reg done_q;
	reg invalid_q;
	reg [SW-1:0] wait_q;
	reg [31:0] pos_q;
	reg [31:0] pos_mark_q;
	reg [15:0] acc_q;
	reg [3:0] sector_q;
	reg [3:0] ref_sector_q;
	reg [15:0] ref_acc_q;
	reg ref_valid_q;
	wire step_up;
	wire step_dn;
	wire index_hit;
	wire wr_en;
	wire acc_start;
	wire start_req;
	wire update_req;
	wire busy;

	// -----------------------------------------
	// Encoder front end
	// -----------------------------------------
	aphi_quad u_quad (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.enc_a(enc_a),
		.enc_b(enc_b),
		.enc_idx(enc_idx),
		.pol(pol_q),
		.step_up_q(step_up),
		.step_dn_q(step_dn),
		.index_hit_q(index_hit)
	);

	// -----------------------------------------
	// APB access: one wait state, pready from a flop
	// -----------------------------------------
	assign wr_en = psel & penable & pready_q & pwrite;
	// First access cycle of any transfer, read or write
	assign acc_start = psel & penable & ~pready_q;
	assign start_req = wr_en && paddr == `APHI_OFS_CTRL && pwdata[`APHI_CTRL_START];
	assign update_req = wr_en && paddr == `APHI_OFS_CTRL && pwdata[`APHI_CTRL_UPDATE];
	assign busy = ~state_q[0];

	// Read data and error latched in the first access cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			prdata_q <= 32'h00000000;
			pslverr_q <= 1'b0;
		end else if (ce) begin
			pready_q <= acc_start;
			if (acc_start) begin
				pslverr_q <= 1'b0;
				prdata_q <= 32'h00000000;
				case (paddr)
				`APHI_OFS_CTRL: prdata_q <= 32'h00000000;
				`APHI_OFS_OUTFMT: prdata_q <= {30'h0, outfmt_q};
				`APHI_OFS_PHASES: prdata_q <= {30'h0, phases_q};
				`APHI_OFS_CPC: prdata_q <= {16'h0, cpc_q};
				`APHI_OFS_METHOD: prdata_q <= {31'h0, method_q};
				`APHI_OFS_LOOP: prdata_q <= {31'h0, loop_on_q};
				`APHI_OFS_SETTLE: prdata_q <= settle_q;
				`APHI_OFS_DRIVE: prdata_q <= {{16{drive_q[15]}}, drive_q};
				`APHI_OFS_STATUS: prdata_q <= {29'h0, busy, invalid_q, done_q};
				`APHI_OFS_POSITION: prdata_q <= pos_q;
				`APHI_OFS_POLARITY: prdata_q <= {29'h0, pol_q};
				`APHI_OFS_IDXCORR: prdata_q <= {31'h0, idxcorr_q};
				default: pslverr_q <= 1'b1;
				endcase
			end else begin
				pslverr_q <= 1'b0;
			end
		end
	end

	// Writable settings; unmapped writes answer with an error, read-only writes are ignored without one
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			outfmt_q <= `APHI_FMT_DAC;
			phases_q <= `APHI_RST_PHASES;
			cpc_q <= `APHI_RST_CPC;
			method_q <= `APHI_METHOD_ALGO;
			loop_on_q <= 1'b0;
			settle_q <= `APHI_RST_SETTLE;
			drive_q <= 16'h0000;
			applied_q <= 16'h0000;
			pol_q <= 3'h0;
			idxcorr_q <= 1'b0;
		end else if (ce) begin
			if (wr_en) begin
				case (paddr)
				// Code 3 is not a format, so it is ignored
				`APHI_OFS_OUTFMT: if (pwdata[1:0] != 2'h3) outfmt_q <= pwdata[1:0];
				// Only two or three phases are accepted
				`APHI_OFS_PHASES: if (pwdata[1]) phases_q <= pwdata[1:0];
				// Zero would stall the angle tracker, so it is refused
				`APHI_OFS_CPC: if (pwdata[15:0] != 16'h0000) cpc_q <= pwdata[15:0];
				`APHI_OFS_METHOD: method_q <= pwdata[0];
				`APHI_OFS_LOOP: loop_on_q <= pwdata[0];
				`APHI_OFS_SETTLE: settle_q <= pwdata[SW-1:0];
				`APHI_OFS_DRIVE: drive_q <= pwdata[15:0];
				`APHI_OFS_POLARITY: pol_q <= pwdata[2:0];
				`APHI_OFS_IDXCORR: idxcorr_q <= pwdata[0];
				default: ;
				endcase
			end
			// Open-loop level takes effect only on update
			if (update_req) begin
				applied_q <= drive_q;
			end
		end
	end

	// -----------------------------------------
	// Phasing sequencer: two excitations, each held for the settle time
	// -----------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= S_IDLE;
			wait_q <= {SW{1'b0}};
			done_q <= 1'b0;
			invalid_q <= 1'b0;
			pos_mark_q <= 32'h00000000;
		end else if (ce) begin
			case (state_q)
			S_IDLE: begin
				// Hall and other methods are not handled here
				if (start_req && method_q == `APHI_METHOD_ALGO) begin
					state_q <= S_STEP1;
					wait_q <= settle_q;
					done_q <= 1'b0;
					invalid_q <= 1'b0;
				end
			end
			S_STEP1: begin
				// Rotor pulled to the zero angle
				if (wait_q == {SW{1'b0}}) begin
					state_q <= S_STEP2;
					wait_q <= settle_q;
					pos_mark_q <= pos_q;
				end else begin
					wait_q <= wait_q - 1'b1;
				end
			end
			S_STEP2: begin
				// Field advanced a quarter turn; positive drive must raise the count
				if (wait_q == {SW{1'b0}}) begin
					state_q <= S_IDLE;
					done_q <= 1'b1;
					invalid_q <= ($signed(pos_q - pos_mark_q) <= 0);
				end else begin
					wait_q <= wait_q - 1'b1;
				end
			end
			default: state_q <= S_IDLE;
			endcase
		end
	end

	// -----------------------------------------
	// Position and electrical angle tracking
	// -----------------------------------------
	// Angle is tracked in twelfths of a cycle by error accumulation, avoiding a divider
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pos_q <= 32'h00000000;
			acc_q <= 16'h0000;
			sector_q <= 4'h0;
			ref_sector_q <= 4'h0;
			ref_acc_q <= 16'h0000;
			ref_valid_q <= 1'b0;
		end else if (ce) begin
			if (step_up) begin
				pos_q <= pos_q + 32'h00000001;
			end else if (step_dn) begin
				pos_q <= pos_q - 32'h00000001;
			end
			if (state_q == S_STEP2 && wait_q == {SW{1'b0}}) begin
				// Rotor rests at the quarter angle: that is the derived phasing
				sector_q <= `APHI_SECTOR_QUARTER;
				acc_q <= 16'h0000;
				ref_valid_q <= 1'b0;
			end else if (index_hit && idxcorr_q && done_q) begin
				// First index sets the reference, later ones remove lost counts
				if (ref_valid_q) begin
					sector_q <= ref_sector_q;
					acc_q <= ref_acc_q;
				end else begin
					ref_sector_q <= sector_q;
					ref_acc_q <= acc_q;
					ref_valid_q <= 1'b1;
				end
			end else if (step_up) begin
				if ({12'h0, `APHI_SECTORS} + acc_q >= cpc_q) begin
					acc_q <= acc_q + {12'h0, `APHI_SECTORS} - cpc_q;
					sector_q <= sec_add(sector_q, 4'h1);
				end else begin
					acc_q <= acc_q + {12'h0, `APHI_SECTORS};
				end
			end else if (step_dn) begin
				if (acc_q < {12'h0, `APHI_SECTORS}) begin
					acc_q <= acc_q + cpc_q - {12'h0, `APHI_SECTORS};
					sector_q <= sec_add(sector_q, `APHI_SECTORS - 4'h1);
				end else begin
					acc_q <= acc_q - {12'h0, `APHI_SECTORS};
				end
			end
		end
	end

	// -----------------------------------------
	// Commutation and output formatting
	// -----------------------------------------
	// Sector sum modulo twelve
	function [3:0] sec_add;
		input [3:0] a;
		input [3:0] b;
		reg [4:0] s;
		begin
			s = {1'b0, a} + {1'b0, b};
			sec_add = (s >= {1'b0, `APHI_SECTORS}) ? s[3:0] - `APHI_SECTORS : s[3:0];
		end
	endfunction

	// Sine at 30 degree steps, full scale 32767
	function [15:0] sine12;
		input [3:0] k;
		begin
			case (k)
			4'h1, 4'h5: sine12 = 16'h4000;
			4'h2, 4'h4: sine12 = 16'h6EDA;
			4'h3: sine12 = 16'h7FFF;
			4'h7, 4'hB: sine12 = 16'hC000;
			4'h8, 4'hA: sine12 = 16'h9126;
			4'h9: sine12 = 16'h8001;
			default: sine12 = 16'h0000;
			endcase
		end
	endfunction

	// Scale the signed command by the phase sine
	function [15:0] scale;
		input [15:0] cmd;
		input [15:0] s;
		reg [31:0] p;
		begin
			p = $signed(cmd) * $signed(s);
			scale = p[30:15];
		end
	endfunction

	reg [15:0] cmd_sel;
	reg [3:0] ang;
	reg [3:0] shift;
	reg [15:0] va;
	reg [15:0] vb;
	reg [15:0] vc;
	// Command source: phasing drive, servo when closed loop, else applied level
	always @* begin
		cmd_sel = busy ? drive_q : (loop_on_q ? servo_cmd : applied_q);
		ang = busy ? (state_q[1] ? `APHI_SECTOR_ALIGN : `APHI_SECTOR_QUARTER) : sector_q;
		shift = phases_q[0] ? `APHI_SHIFT_3PH : `APHI_SHIFT_2PH;
		// Signed command as a fraction of full power; sign sets direction
		va = scale(cmd_sel, sine12(ang));
		vb = scale(cmd_sel, sine12(sec_add(ang, shift)));
		vc = phases_q[0] ? scale(cmd_sel, sine12(sec_add(ang, shift + shift))) : 16'h0000;
	end

	// Magnitude with sign
	function [15:0] mag;
		input [15:0] v;
		begin
			mag = v[15] ? (~v + 16'h0001) : v;
		end
	endfunction

	// Encode per format: DAC signed, sign/magnitude, or offset around half scale
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_a_q <= 16'h0000;
			phase_b_q <= 16'h0000;
			phase_c_q <= 16'h0000;
			phase_sign_q <= 3'h0;
			fmt_sel_q <= 3'h1;
		end else if (ce) begin
			fmt_sel_q <= {outfmt_q == `APHI_FMT_PWM_5050, outfmt_q == `APHI_FMT_PWM_SM,
				outfmt_q == `APHI_FMT_DAC};
			phase_sign_q <= {vc[15], vb[15], va[15]};
			case (outfmt_q)
			`APHI_FMT_PWM_SM: begin
				phase_a_q <= mag(va);
				phase_b_q <= mag(vb);
				phase_c_q <= mag(vc);
			end
			`APHI_FMT_PWM_5050: begin
				phase_a_q <= va ^ 16'h8000;
				phase_b_q <= vb ^ 16'h8000;
				phase_c_q <= phases_q[0] ? (vc ^ 16'h8000) : 16'h0000;
			end
			default: begin
				phase_a_q <= va;
				phase_b_q <= vb;
				phase_c_q <= vc;
			end
			endcase
		end
	end
endmodule
`default_nettype wire

// file: pkg/aphi_defs.vh
// Register map, field layout, reset values and codes of the phasing sequencer
`ifndef APHI_DEFS_VH
`define APHI_DEFS_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define APHI_OFS_CTRL 8'h00
`define APHI_OFS_OUTFMT 8'h04
`define APHI_OFS_PHASES 8'h08
`define APHI_OFS_CPC 8'h0C
`define APHI_OFS_METHOD 8'h10
`define APHI_OFS_LOOP 8'h14
`define APHI_OFS_SETTLE 8'h18
`define APHI_OFS_DRIVE 8'h1C
`define APHI_OFS_STATUS 8'h20
`define APHI_OFS_POSITION 8'h24
`define APHI_OFS_POLARITY 8'h28
`define APHI_OFS_IDXCORR 8'h2C
// ----------------------------------------
// Field positions
// ----------------------------------------
`define APHI_CTRL_START 0
`define APHI_CTRL_UPDATE 1
`define APHI_ST_DONE 0
`define APHI_ST_INVALID 1
`define APHI_ST_BUSY 2
`define APHI_POL_A 0
`define APHI_POL_B 1
`define APHI_POL_IDX 2
// ----------------------------------------
// Codes and reset values
// ----------------------------------------
`define APHI_FMT_DAC 2'h0
`define APHI_FMT_PWM_SM 2'h1
`define APHI_FMT_PWM_5050 2'h2
`define APHI_METHOD_ALGO 1'h0
`define APHI_RST_PHASES 2'h3
`define APHI_RST_CPC 16'h0400
`define APHI_RST_SETTLE 32'h00000FA0
`define APHI_SECTORS 4'hC
`define APHI_SECTOR_ALIGN 4'h0
`define APHI_SECTOR_QUARTER 4'h3
`define APHI_SHIFT_3PH 4'h4
`define APHI_SHIFT_2PH 4'h3
`endif

// file: hw/aphi_quad.v
// Quadrature decoder with channel inversion and gated index detection
`timescale 1ns/1ns
`default_nettype none
module aphi_quad (
	// Clock, reset, enable
	input wire pclk,
	input wire presetn,
	input wire ce,
	// Encoder pins and polarity
	input wire enc_a,
	input wire enc_b,
	input wire enc_idx,
	input wire [2:0] pol,
	// Decoded events
	output reg step_up_q,
	output reg step_dn_q,
	output reg index_hit_q
);
	wire a_l;
	wire b_l;
	wire idx_l;
	wire [1:0] ph_now;
	reg [1:0] ph_q;
	reg primed_q;
	// Inverting one channel reverses the counting direction
	assign a_l = enc_a ^ pol[0];
	assign b_l = enc_b ^ pol[1];
	// Index is active low unless inverted
	assign idx_l = ~enc_idx ^ pol[2];
	// Binary position within one quadrature cycle, decoded from the Gray pair
	assign ph_now = {b_l, a_l ^ b_l};

	// -----------------------------------------
	// Step and index detection
	// -----------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ph_q <= 2'h0;
			primed_q <= 1'b0;
			step_up_q <= 1'b0;
			step_dn_q <= 1'b0;
			index_hit_q <= 1'b0;
		end else if (ce) begin
			ph_q <= ph_now;
			// First sample after reset only loads the phase, so no false step
			primed_q <= 1'b1;
			step_up_q <= primed_q & (ph_now == ph_q + 2'h1);
			step_dn_q <= primed_q & (ph_now == ph_q - 2'h1);
			// Capture only with index, A and B all active; inverting A or B can block it
			index_hit_q <= idx_l & a_l & b_l;
		end
	end
endmodule
`default_nettype wire

// file: dv/aphi_properties.sv
// Bus and sequencing assertions for the phasing sequencer
`timescale 1ns/1ns
`default_nettype none
module aphi_properties (
	// Clock, reset, enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// Register bus
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata_q,
	input wire logic pready_q,
	input wire logic pslverr_q,
	// Format select
	input wire logic [2:0] fmt_sel_q
);
	logic wr, rs, m_q, dn_q;
	logic [31:0] st_q;
	logic [32:0] cnt_q;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Completed write and completed status read
	assign wr = psel && penable && pready_q && pwrite;
	assign rs = pready_q && !pwrite && paddr == 8'h20;
	// Shadow of the run length, two cycles of margin so edges never judge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= 32'hFA0;
			m_q <= 1'b0;
			dn_q <= 1'b0;
			cnt_q <= 33'h0;
		end else begin
			if (wr && paddr == 8'h18)
				st_q <= pwdata;
			if (wr && paddr == 8'h10)
				m_q <= pwdata[0];
			if (wr && paddr == 8'h00 && pwdata[0] && !m_q && cnt_q == 33'h0) begin
				cnt_q <= {st_q, 1'b0} + 33'h4;
				dn_q <= 1'b0;
			end else if (ce && cnt_q != 33'h0) begin
				cnt_q <= cnt_q - 33'h1;
				dn_q <= cnt_q == 33'h1;
			end
		end
	end
	acc_wait_a: assert property (psel && penable && !pready_q |=> pready_q)
		else $error("no ready after access");
	ready_pulse_a: assert property (pready_q |=> !pready_q)
		else $error("ready held too long");
	bad_addr_a: assert property (psel && penable && !pready_q && paddr > 8'h2C |=> pslverr_q)
		else $error("no error on unmapped address");
	good_addr_a: assert property (psel && penable && !pready_q && paddr < 8'h30 && paddr[1:0] == 2'h0
		|=> !pslverr_q)
		else $error("error on mapped address");
	ctrl_read_a: assert property (pready_q && !pwrite && paddr == 8'h00 |-> prdata_q == 32'h0)
		else $error("control reads nonzero");
	fmt_hot_a: assert property ($onehot(fmt_sel_q))
		else $error("format select not one-hot");
	busy_read_a: assert property (rs && cnt_q > 33'h4 |-> prdata_q[2:0] == 3'h4)
		else $error("status wrong while phasing");
	done_read_a: assert property (rs && dn_q |-> prdata_q[0] && !prdata_q[2])
		else $error("status wrong after phasing");
	cover property (rs && dn_q);
	cover property (pready_q && pslverr_q);
	cover property (fmt_sel_q[2]);
endmodule
bind aphi_top aphi_properties aphi_properties_i (.pclk(pclk), .presetn(presetn), .ce(ce),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q), .fmt_sel_q(fmt_sel_q));
`default_nettype wire

// file: dv/aphi_enc_model.sv
// Motor and encoder stand-in that turns forward while asked to run
`timescale 1ns/1ns
`default_nettype none
module aphi_enc_model (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Motion request
	input wire logic run,
	// Encoder pins
	output logic enc_a,
	output logic enc_b,
	output logic enc_idx
);
	logic [4:0] pos_q;
	// One count every eight cycles keeps the decoder well inside its rate
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pos_q <= 5'h0;
		else if (run)
			pos_q <= pos_q + 5'h1;
	end
	// Order 00, 10, 11, 01 counts up; index idles inactive high
	assign enc_a = pos_q[4] ^ pos_q[3];
	assign enc_b = pos_q[4];
	assign enc_idx = 1'b1;
endmodule
`default_nettype wire

// file: dv/aphi_top_test.sv
// Self-checking bench for the phasing sequencer
`timescale 1ns/1ns
`default_nettype none
module aphi_top_test;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, run = 1'b0;
	logic [7:0] paddr = 8'h0;
	logic [31:0] pwdata = 32'h0, r, prdata_q;
	logic [15:0] servo_cmd = 16'h0, phase_a_q, phase_b_q, phase_c_q;
	logic pready_q, pslverr_q, e, enc_a, enc_b, enc_idx;
	logic [2:0] phase_sign_q, fmt_sel_q;
	int fails = 0, samples_checked = 0, cyc = 0;
	// Drive {command, format, expected top twelve bits}
	logic [31:0] tbl [5] = '{32'h08080080, 32'hF7F80F7F, 32'hF7F81080, 32'h08082880, 32'hF7F8277F};
	aphi_top aphi_top_i (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q), .enc_a(enc_a),
		.enc_b(enc_b), .enc_idx(enc_idx), .servo_cmd(servo_cmd), .phase_a_q(phase_a_q),
		.phase_b_q(phase_b_q), .phase_c_q(phase_c_q), .phase_sign_q(phase_sign_q),
		.fmt_sel_q(fmt_sel_q));
	aphi_enc_model aphi_enc_model_i (.pclk(pclk), .presetn(presetn), .run(run),
		.enc_a(enc_a), .enc_b(enc_b), .enc_idx(enc_idx));
	// Clock and hang guard
	always #5 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 6000) begin
			fails++;
			print_verdict;
		end
	end
	// ------
	// Shared tasks
	// ------
	task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
		samples_checked++;
		if (s !== x) begin
			fails++;
			$display("unexpected %s expected %h seen %h", nm, x, s);
		end
	endtask
	// Whole bus transfer; no fixed latency assumed
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready_q !== 1'b1);
		r = prdata_q;
		e = pslverr_q;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rd(input string nm, input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(nm, r, x);
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// ------
	// Scenarios
	// ------
	task t_reset;
		logic [31:0] x;
		for (int i = 1; i < 12; i++) begin
			x = i == 2 ? 32'h3 : i == 3 ? 32'h400 : i == 6 ? 32'hFA0 : 32'h0;
			rd("reset value", 8'(i * 4), x);
		end
		chk("format select", {29'h0, fmt_sel_q}, 32'h1);
	endtask
	task t_regs;
		apb(1'b1, 8'h18, 32'h28);
		rd("settle", 8'h18, 32'h28);
		apb(1'b1, 8'h1C, 32'h8001);
		rd("drive", 8'h1C, 32'hFFFF8001);
		apb(1'b1, 8'h04, 32'h3);
		rd("format", 8'h04, 32'h0);
		apb(1'b1, 8'h08, 32'h1);
		rd("phases", 8'h08, 32'h3);
		rd("control", 8'h00, 32'h0);
		apb(1'b0, 8'h30, 32'h0);
		chk("bus error", {31'h0, e}, 32'h1);
	endtask
	// Host order: format, phases, counts, method, open loop, settle, drive
	task t_phase(input logic [1:0] ph, input logic mv, input logic inv);
		apb(1'b1, 8'h04, 32'h0);
		apb(1'b1, 8'h08, {30'h0, ph});
		apb(1'b1, 8'h0C, 32'h400);
		apb(1'b1, 8'h10, 32'h0);
		apb(1'b1, 8'h14, 32'h0);
		apb(1'b1, 8'h18, 32'h28);
		apb(1'b1, 8'h1C, 32'h808);
		run <= mv;
		apb(1'b1, 8'h00, 32'h1);
		rd("busy", 8'h20, 32'h4);
		repeat (6) @(posedge pclk);
		chk("first step", {16'h0, phase_a_q}, 32'h0);
		chk("first step b", {16'h0, phase_b_q}, ph == 2'h2 ? 32'h807 : 32'h6F4);
		repeat (45) @(posedge pclk);
		chk("second step", {20'h0, phase_a_q[15:4]}, 32'h80);
		if (ph == 2'h2)
			chk("third phase", {16'h0, phase_c_q}, 32'h0);
		do apb(1'b0, 8'h20, 32'h0); while (r[0] !== 1'b1);
		run <= 1'b0;
		chk("result", r, {30'h0, inv, 1'b1});
	endtask
	task t_open;
		logic [31:0] t;
		for (int i = 0; i < 5; i++) begin
			t = tbl[i];
			apb(1'b1, 8'h04, {30'h0, t[13:12]});
			apb(1'b1, 8'h1C, {16'h0, t[31:16]});
			apb(1'b1, 8'h00, 32'h2);
			repeat (3) @(posedge pclk);
			chk("open loop", {19'h0, phase_sign_q[0], phase_a_q[15:4]}, {19'h0, t[31], t[11:0]});
		end
		apb(1'b1, 8'h04, 32'h0);
		servo_cmd <= 16'h0808;
		apb(1'b1, 8'h14, 32'h1);
		repeat (3) @(posedge pclk);
		chk("servo drive", {20'h0, phase_a_q[15:4]}, 32'h80);
	endtask
	// Inverted channel must turn forward motion into falling counts
	task t_pol;
		logic [31:0] p;
		apb(1'b1, 8'h28, 32'h1);
		apb(1'b0, 8'h24, 32'h0);
		p = r;
		run <= 1'b1;
		repeat (100) @(posedge pclk);
		run <= 1'b0;
		apb(1'b0, 8'h24, 32'h0);
		chk("reverse count", {31'h0, $signed(r - p) < 0}, 32'h1);
	endtask
	// Main sequence
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_regs;
		t_phase(2'h2, 1'b0, 1'b1);
		t_phase(2'h3, 1'b1, 1'b0);
		t_open;
		t_pol;
		print_verdict;
	end
endmodule
`default_nettype wire
